// ---- core/csk_pkg.sv ----
// Shared constants and types for the compare-and-skip decoder
package csk_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Opcode field: instruction bits 15:9
  localparam int unsigned OPC_MSB = 15;
  localparam int unsigned OPC_LSB = 9;
  localparam logic [6:0] OPC_SKIP_GREATER = 7'h32;
  localparam logic [6:0] OPC_SKIP_LESS = 7'h30;
  localparam int unsigned ACCESS_BIT = 8;
  localparam int unsigned FADDR_MSB = 7;

  // Fixed access bank: low file addresses map to the lowest bank, high ones to the top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_BANK_LO = 4'h0;
  localparam logic [3:0] ACCESS_BANK_HI = 4'hf;
  localparam logic [3:0] BANK_RESET = 4'h0;

  typedef enum logic [1:0] {
    CSK_EXEC,
    CSK_SKIP1,
    CSK_SKIP2
  } csk_mode_t;

  typedef struct packed {
    logic is_greater;
    logic is_less;
    logic access;
    logic [7:0] faddr;
  } csk_dec_t;

  typedef struct packed {
    csk_mode_t mode;
    csk_dec_t dec;
    logic [7:0] fdata;
    logic skip;
    logic two_word;
  } csk_state_t;

  typedef struct packed {
    logic rd;
    logic [11:0] addr;
  } csk_file_req_t;

endpackage

// ---- core/csk_phase_gen.sv ----
// Four-phase generator splitting each instruction cycle into Q1..Q4
`timescale 1ns/1ps
module csk_phase_gen (
  input wire logic clk_i,
  input wire logic resetn_i,
  output logic [1:0] phase_o
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q + 2'h1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= csk_pkg::PH_Q1;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign phase_o = cnt_q;
endmodule

// ---- core/csk_cmp.sv ----
// Unsigned subtract-and-compare of a file byte against the working register
`timescale 1ns/1ps
module csk_cmp #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] file_i,
  input wire logic [WIDTH-1:0] working_register_i,
  output logic greater_o,
  output logic less_o
);
  logic [WIDTH:0] diff;

  // Borrow out of the subtraction gives less; no borrow and a nonzero difference gives greater
  assign diff = {1'b0, file_i} - {1'b0, working_register_i};
  assign less_o = diff[WIDTH];
  assign greater_o = !diff[WIDTH] && (diff[WIDTH-1:0] != '0);
endmodule

// ---- core/csk_decoder.sv ----
// Compare-and-skip instruction decoder and executor
`timescale 1ns/1ps
// Functional notes
// - Opcodes 0110010a and 0110000a, then file address
// - Greater variant skips when file exceeds working
// - Less variant skips when file below working
// - Unsigned subtract, result dropped, no flags
// - One word; one cycle, two if skipping
// - Skipping a two-word instruction takes three
// - Skip cycles are NOP in every phase
// - Access bit zero uses fixed access bank
// - Access bit one uses bank select register
// - File address 0..255, access bit 0/1
module csk_decoder (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic fetched_two_word_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] working_register_i,
  input wire logic [7:0] file_data_i,
  output logic [1:0] phase_o,
  output logic file_rd_o,
  output logic [11:0] file_addr_o,
  output logic file_wr_o,
  output logic status_we_o,
  output logic discard_o,
  output logic nop_cycle_o,
  output logic done_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Phase and compare
  logic [1:0] phase;
  logic greater;
  logic less;
  csk_pkg::csk_state_t st_q;
  csk_pkg::csk_state_t st_d;
  csk_pkg::csk_file_req_t req;
  logic is_cmp;
  logic skip_now;

  csk_phase_gen u_phase (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .phase_o(phase)
  );

  csk_cmp #(
    .WIDTH(8)
  ) u_cmp (
    .file_i(st_q.fdata),
    .working_register_i(working_register_i),
    .greater_o(greater),
    .less_o(less)
  );

  assign is_cmp = st_q.dec.is_greater || st_q.dec.is_less;
  assign skip_now = (st_q.dec.is_greater && greater) || (st_q.dec.is_less && less);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q.mode)
      csk_pkg::CSK_EXEC: begin
        if (phase == csk_pkg::PH_Q1) begin
          // Q1: decode; a missing instruction decodes as neither variant
          st_d.dec.is_greater = instr_valid_i &&
            (instr_i[csk_pkg::OPC_MSB:csk_pkg::OPC_LSB] == csk_pkg::OPC_SKIP_GREATER);
          st_d.dec.is_less = instr_valid_i &&
            (instr_i[csk_pkg::OPC_MSB:csk_pkg::OPC_LSB] == csk_pkg::OPC_SKIP_LESS);
          st_d.dec.access = instr_i[csk_pkg::ACCESS_BIT];
          st_d.dec.faddr = instr_i[csk_pkg::FADDR_MSB:0];
          st_d.skip = 1'b0;
          st_d.two_word = 1'b0;
        end else if (phase == csk_pkg::PH_Q2) begin
          st_d.fdata = file_data_i;
        end else if (phase == csk_pkg::PH_Q3) begin
          st_d.skip = is_cmp && skip_now;
        end else begin
          // Q4: nothing is written; skip switches the next cycle to a NOP
          st_d.two_word = fetched_two_word_i;
          if (st_q.skip) begin
            st_d.mode = csk_pkg::CSK_SKIP1;
          end
        end
      end
      csk_pkg::CSK_SKIP1: begin
        if (phase == csk_pkg::PH_Q4) begin
          if (st_q.two_word) begin
            st_d.mode = csk_pkg::CSK_SKIP2;
          end else begin
            st_d.mode = csk_pkg::CSK_EXEC;
          end
        end
      end
      csk_pkg::CSK_SKIP2: begin
        if (phase == csk_pkg::PH_Q4) begin
          st_d.mode = csk_pkg::CSK_EXEC;
        end
      end
      default: begin
        st_d.mode = csk_pkg::CSK_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '{mode: csk_pkg::CSK_EXEC, dec: '0, fdata: 8'h00, skip: 1'b0, two_word: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    req.rd = (st_q.mode == csk_pkg::CSK_EXEC) && (phase == csk_pkg::PH_Q2) && is_cmp;
    if (!st_q.dec.access) begin
      // Fixed access bank ignores the bank select register
      if (st_q.dec.faddr < csk_pkg::ACCESS_SPLIT) begin
        req.addr = {csk_pkg::ACCESS_BANK_LO, st_q.dec.faddr};
      end else begin
        req.addr = {csk_pkg::ACCESS_BANK_HI, st_q.dec.faddr};
      end
    end else begin
      req.addr = {bank_select_register_i, st_q.dec.faddr};
    end
  end

  assign phase_o = phase;
  assign file_rd_o = req.rd;
  assign file_addr_o = req.addr;
  // Compare never writes back or touches status, in any cycle
  assign file_wr_o = 1'b0;
  assign status_we_o = 1'b0;
  assign nop_cycle_o = st_q.mode != csk_pkg::CSK_EXEC;
  assign discard_o = (st_q.mode == csk_pkg::CSK_EXEC) && (phase == csk_pkg::PH_Q4) && st_q.skip;
  assign busy_o = is_cmp || (st_q.mode != csk_pkg::CSK_EXEC);
  always_comb begin
    done_o = 1'b0;
    if (phase == csk_pkg::PH_Q4) begin
      case (st_q.mode)
        csk_pkg::CSK_EXEC: done_o = is_cmp && !st_q.skip;
        csk_pkg::CSK_SKIP1: done_o = !st_q.two_word;
        csk_pkg::CSK_SKIP2: done_o = 1'b1;
        default: done_o = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic [3:0] len_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      len_q <= 4'h0;
    end else if (done_o) begin
      len_q <= 4'h0;
    end else if (busy_o && !((st_q.mode == csk_pkg::CSK_EXEC) && (phase == csk_pkg::PH_Q1))) begin
      // The Q1 edge of an execute cycle still sees the previous decode, so it is not counted
      len_q <= len_q + 4'h1;
    end
  end

  decode_gt_a: assert property ((phase == csk_pkg::PH_Q1) && instr_valid_i &&
    (instr_i[15:9] == 7'h32) && (st_q.mode == csk_pkg::CSK_EXEC) |=> st_q.dec.is_greater)
    else $error("greater opcode not decoded");
  decode_lt_a: assert property ((phase == csk_pkg::PH_Q1) && instr_valid_i &&
    (instr_i[15:9] == 7'h30) && (st_q.mode == csk_pkg::CSK_EXEC) |=> st_q.dec.is_less)
    else $error("less opcode not decoded");
  skip_gt_a: assert property ((phase == csk_pkg::PH_Q3) && st_q.dec.is_greater &&
    (st_q.mode == csk_pkg::CSK_EXEC) && (st_q.fdata > working_register_i)
    |-> ##1 discard_o ##1 nop_cycle_o)
    else $error("greater skip not taken");
  skip_lt_a: assert property ((phase == csk_pkg::PH_Q3) && st_q.dec.is_less &&
    (st_q.mode == csk_pkg::CSK_EXEC) && (st_q.fdata < working_register_i)
    |-> ##1 discard_o ##1 nop_cycle_o)
    else $error("less skip not taken");
  no_write_a: assert property (!file_wr_o && !status_we_o)
    else $error("compare wrote state");
  one_cycle_a: assert property (done_o && !nop_cycle_o |-> len_q == 4'h2)
    else $error("non-skip length wrong");
  skip_len_a: assert property (done_o && nop_cycle_o |-> (len_q == 4'h6) || (len_q == 4'ha))
    else $error("skip length wrong");
  three_cycle_a: assert property ($rose(st_q.mode == csk_pkg::CSK_SKIP2) |-> ##3 done_o)
    else $error("two-word skip length wrong");
  nop_quiet_a: assert property (nop_cycle_o |-> !file_rd_o)
    else $error("skip cycle did work");
  access_bank_a: assert property (file_rd_o && !st_q.dec.access |->
    (file_addr_o[11:8] == 4'h0) || (file_addr_o[11:8] == 4'hf))
    else $error("access bank wrong");
  bsr_bank_a: assert property (file_rd_o && st_q.dec.access |->
    file_addr_o[11:8] == bank_select_register_i)
    else $error("bank select ignored");
  read_q2_a: assert property (file_rd_o |-> phase == csk_pkg::PH_Q2)
    else $error("read outside Q2");

  skip_once_c: cover property (discard_o ##4 done_o);
  skip_two_c: cover property (st_q.mode == csk_pkg::CSK_SKIP2);
  no_skip_c: cover property (done_o && !nop_cycle_o);
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the compare-and-skip decoder
`timescale 1ns/1ps
module tb_top;
  logic clk_i, resetn_i, instr_valid_i, fetched_two_word_i;
  logic [15:0] instr_i;
  logic [3:0] bank_select_register_i;
  logic [7:0] working_register_i, file_data_i;
  logic [1:0] phase_o;
  logic [11:0] file_addr_o;
  logic file_rd_o, file_wr_o, status_we_o, discard_o, nop_cycle_o, done_o, busy_o;
  int bad_count = 0;
  int cmp_count = 0;

  csk_decoder csk_decoder_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .fetched_two_word_i(fetched_two_word_i),
    .bank_select_register_i(bank_select_register_i),
    .working_register_i(working_register_i), .file_data_i(file_data_i),
    .phase_o(phase_o), .file_rd_o(file_rd_o), .file_addr_o(file_addr_o),
    .file_wr_o(file_wr_o), .status_we_o(status_we_o), .discard_o(discard_o),
    .nop_cycle_o(nop_cycle_o), .done_o(done_o), .busy_o(busy_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////
  // Issues one word at a Q1 edge and watches it to completion; exp_n is the clock
  // on which done is due (0: not a compare, nothing may happen)
  task automatic run(input logic [6:0] opc, input logic acc, input logic [7:0] fa,
                     input logic [7:0] fd, input logic [7:0] wr, input logic [3:0] bk,
                     input logic tw, input int exp_n, input logic [11:0] exp_addr);
    int done_at;
    int nops;
    int rds;
    logic side;
    done_at = 0;
    nops = 0;
    rds = 0;
    side = 1'b0;
    // Drive in Q4 so the word already stands at the following Q1 (decode) edge
    do @(negedge clk_i); while (phase_o !== csk_pkg::PH_Q4);
    @(posedge clk_i);
    instr_i <= {opc, acc, fa};
    instr_valid_i <= 1'b1;
    file_data_i <= fd;
    working_register_i <= wr;
    bank_select_register_i <= bk;
    fetched_two_word_i <= tw;
    @(posedge clk_i);
    // Valid stays up through the skip cycles so a wrongly decoded skipped word shows
    for (int n = 1; n <= 12 && done_at == 0; n++) begin
      @(negedge clk_i);
      if (n == 1) begin
        chk1(busy_o, exp_n != 0);
        chk1(phase_o == csk_pkg::PH_Q2, 1'b1);
        if (exp_n != 0) chk12(file_addr_o, exp_addr);
      end
      if (n == 3) chk1(discard_o, exp_n > 3);
      rds += int'(file_rd_o === 1'b1);
      nops += int'(nop_cycle_o === 1'b1);
      side = side | (file_wr_o !== 1'b0) | (status_we_o !== 1'b0);
      if (done_o === 1'b1) done_at = n;
      @(posedge clk_i);
      if (n + 1 == exp_n) instr_valid_i <= 1'b0;
    end
    instr_valid_i <= 1'b0;
    chkn(done_at, exp_n);
    chkn(rds, exp_n != 0 ? 1 : 0);
    chkn(nops, exp_n > 3 ? exp_n - 3 : 0);
    chk1(side, 1'b0);
  endtask

  ////////////////////////////////////////
  task automatic greater_cases();
    run(csk_pkg::OPC_SKIP_GREATER, 1'b1, 8'h90, 8'h81, 8'h80, 4'h5, 1'b0, 7, 12'h590);
    run(csk_pkg::OPC_SKIP_GREATER, 1'b1, 8'h10, 8'h80, 8'h80, 4'ha, 1'b1, 3, 12'ha10);
    run(csk_pkg::OPC_SKIP_GREATER, 1'b0, 8'hff, 8'hff, 8'h00, 4'h3, 1'b1, 11, 12'hfff);
    run(csk_pkg::OPC_SKIP_GREATER, 1'b0, 8'h00, 8'h00, 8'hff, 4'h3, 1'b0, 3, 12'h000);
  endtask

  task automatic less_cases();
    run(csk_pkg::OPC_SKIP_LESS, 1'b0, 8'h7f, 8'h7f, 8'h80, 4'h9, 1'b1, 11, 12'h07f);
    run(csk_pkg::OPC_SKIP_LESS, 1'b1, 8'h80, 8'h80, 8'h7f, 4'hc, 1'b0, 3, 12'hc80);
    run(csk_pkg::OPC_SKIP_LESS, 1'b1, 8'hff, 8'h00, 8'h00, 4'h0, 1'b0, 3, 12'h0ff);
    run(csk_pkg::OPC_SKIP_LESS, 1'b0, 8'h80, 8'h00, 8'h01, 4'h6, 1'b0, 7, 12'hf80);
  endtask

  // Neighbouring opcodes, with equal operands that would skip under neither compare
  task automatic other_opcodes();
    logic [6:0] codes [3] = '{7'h31, 7'h33, 7'h34};
    foreach (codes[i]) run(codes[i], 1'b1, 8'h20, 8'h40, 8'h40, 4'h1, 1'b0, 0, 12'h000);
  endtask

  ////////////////////////////////////////
  initial begin
    resetn_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    fetched_two_word_i = 1'b0;
    bank_select_register_i = 4'h0;
    working_register_i = 8'h00;
    file_data_i = 8'h00;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    greater_cases();
    less_cases();
    other_opcodes();
    stop_test();
  end

  // About 140 clocks are needed; the limit leaves ample margin
  initial begin
    #20000;
    bad_count++;
    stop_test();
  end
endmodule
